//--- dv/tx_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module tx_ctrl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic device_reset_n,
  input wire logic [1:0] rate_range_select,
  input wire logic output_latch_enable,
  input wire logic selftest_latch_enable,
  input wire logic [7:0] shared_enable_bus,
  input wire logic [7:0] serial_output_driver,
  input wire logic [3:0] channel_selftest_active,
  input wire logic [1:0] pll_rate_range,
  input wire logic outputs_settled
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rng;
    $past(presetn) |-> pll_rate_range == (&$past(rate_range_select) ? 2'h1 : $past(rate_range_select));
  endproperty
  a_rng: assert property (p_rng) else $error("pll range wrong");
  property p_dpass;
    output_latch_enable && device_reset_n |=> serial_output_driver == $past(shared_enable_bus);
  endproperty
  a_dpass: assert property (p_dpass) else $error("driver pass wrong");
  property p_dhold;
    $past(presetn) && !output_latch_enable && device_reset_n |=> $stable(serial_output_driver);
  endproperty
  a_dhold: assert property (p_dhold) else $error("driver hold lost");
  property p_dclr; !device_reset_n |=> serial_output_driver == 8'h00; endproperty
  a_dclr: assert property (p_dclr) else $error("drivers not cleared");
  property p_spass; selftest_latch_enable |=> channel_selftest_active == ~$past(shared_enable_bus[3:0]); endproperty
  a_spass: assert property (p_spass) else $error("self-test pass wrong");
  property p_shold;
    $past(presetn) && !selftest_latch_enable && device_reset_n |=> $stable(channel_selftest_active);
  endproperty
  a_shold: assert property (p_shold) else $error("self-test hold lost");
  property p_sclr; !device_reset_n && !selftest_latch_enable |=> channel_selftest_active == 4'h0; endproperty
  a_sclr: assert property (p_sclr) else $error("self-test not cleared");
  // flag registered within fifteen edges of the release edge, seen one edge later
  property p_settle; $rose(device_reset_n) |-> ##[1:16] (outputs_settled || !device_reset_n); endproperty
  a_settle: assert property (p_settle) else $error("outputs never settled");
  cover property ($fell(output_latch_enable));
  cover property ($fell(selftest_latch_enable));
  cover property ($rose(outputs_settled));
endmodule
bind tx_enable_latch_reset_ctrl tx_ctrl_props props_inst (.pclk, .presetn, .device_reset_n, .rate_range_select,
  .output_latch_enable, .selftest_latch_enable, .shared_enable_bus, .serial_output_driver,
  .channel_selftest_active, .pll_rate_range, .outputs_settled);
`default_nettype wire

//--- dv/tx_enable_latch_reset_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tx_enable_latch_reset_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic half_rate_clock_mode, transmit_clock_select, capture_on_reference, config_invalid, outputs_settled;
  logic [1:0] rate_range_select, pll_rate_range;
  logic [3:0] channel_selftest_active;
  logic [7:0] paddr, serial_output_driver;
  logic [31:0] pwdata, prdata, q;
  wire logic device_reset_n, output_latch_enable, selftest_latch_enable;
  wire logic [7:0] shared_enable_bus;
  int failures = 0;
  int tests_run = 0;
  int n;
  // select, half rate, clock select, then expected range, capture, invalid flag
  logic [7:0] rows [5] = '{8'h02, 8'h74, 8'hAA, 8'hD4, 8'h23};
  tx_enable_latch_reset_ctrl tx_enable_latch_reset_ctrl_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .device_reset_n, .rate_range_select, .half_rate_clock_mode, .transmit_clock_select, .output_latch_enable,
    .selftest_latch_enable, .shared_enable_bus, .serial_output_driver, .channel_selftest_active,
    .pll_rate_range, .capture_on_reference, .config_invalid, .outputs_settled);
  tx_host_model host (.pclk, .device_reset_n, .output_latch_enable, .selftest_latch_enable, .shared_enable_bus);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      failures++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // slave latency is not assumed; a stuck bus ends the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 9 && pready !== 1'b1; k++)
      @(posedge pclk);
    {q, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    if (pready !== 1'b1)
    begin
      check(pready, 1'b1);
      complete_run();
    end
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rate_range_select, half_rate_clock_mode, transmit_clock_select} = 4'h4;
    repeat (3) @(posedge pclk);
    check(serial_output_driver, 8'h00);
    presetn <= 1'b1;
    apb(1'b1, tx_ctrl_pkg::CTRL_OFFSET, 32'h0000_0003);
    apb(1'b0, tx_ctrl_pkg::CTRL_OFFSET, 32'h0);
    check(q, 32'h0000_0003);
    apb(1'b0, tx_ctrl_pkg::DRIVER_LATCH_OFFSET, 32'h0);
    check(q, 32'h0000_0000);
    apb(1'b0, tx_ctrl_pkg::SELFTEST_LATCH_OFFSET, 32'h0);
    check(q, 32'h0000_00FF);
    apb(1'b0, 8'h10, 32'h0);
    check({q[30:0], err}, 32'h0000_0001);
    apb(1'b1, tx_ctrl_pkg::CTRL_OFFSET, 32'h0);
    $display("registers done");
    host.set_reset(1'b1);
    for (n = 0; n < 40 && outputs_settled !== 1'b1; n++)
      @(posedge pclk);
    // one edge to sample the release, fewer than the limit to settle, one to see the flag
    check(n <= tx_ctrl_pkg::SETTLE_LIMIT + 1, 1'b1);
    if (n == 40)
      complete_run();
    apb(1'b0, tx_ctrl_pkg::STATUS_OFFSET, 32'h0);
    check(q, 32'h0000_009D);
    $display("settle done");
    foreach (rows[i])
    begin
      {rate_range_select, half_rate_clock_mode, transmit_clock_select} <= rows[i][7:4];
      repeat (2) @(posedge pclk);
      check(pll_rate_range, rows[i][3:2]);
      check(capture_on_reference, rows[i][1]);
      check(config_invalid, rows[i][0]);
    end
    $display("static pins done");
    host.load(1'b0, 8'hA5);
    @(posedge pclk);
    check(serial_output_driver, 8'hA5);
    host.load(1'b1, 8'h0A);
    repeat (3) @(posedge pclk);
    check(serial_output_driver, 8'hA5);
    check(channel_selftest_active, 4'h5);
    apb(1'b0, tx_ctrl_pkg::DRIVER_LATCH_OFFSET, 32'h0);
    check(q, 32'h0000_00A5);
    $display("latches done");
    host.set_reset(1'b0);
    repeat (2) @(posedge pclk);
    check(serial_output_driver, 8'h00);
    check(channel_selftest_active, 4'h0);
    check(outputs_settled, 1'b0);
    apb(1'b0, tx_ctrl_pkg::DRIVER_LATCH_OFFSET, 32'h0);
    check(q, 32'h0000_0000);
    apb(1'b0, tx_ctrl_pkg::SELFTEST_LATCH_OFFSET, 32'h0);
    check(q, 32'h0000_00FF);
    // an open self-test latch is not cleared by the device reset
    host.load(1'b1, 8'h03);
    @(posedge pclk);
    check(channel_selftest_active, 4'hC);
    $display("device reset done");
    complete_run();
  end
endmodule
`default_nettype wire

//--- dv/tx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tx_host_model (
  input wire logic pclk,
  output logic device_reset_n,
  output logic output_latch_enable,
  output logic selftest_latch_enable,
  output logic [7:0] shared_enable_bus
);
  initial
  begin
    {device_reset_n, output_latch_enable, selftest_latch_enable} = 3'h0;
    shared_enable_bus = 8'hFF;
  end
  // applied or released at the next edge
  task automatic set_reset(input logic level);
    device_reset_n <= level;
  endtask
  // one latch open for one edge; bus then floats to its pull-up
  task automatic load(input logic st, input logic [7:0] v);
    {output_latch_enable, selftest_latch_enable, shared_enable_bus} <= {!st, st, v};
    @(posedge pclk);
    {output_latch_enable, selftest_latch_enable, shared_enable_bus} <= {2'h0, 8'hFF};
  endtask
endmodule
`default_nettype wire

//--- rtl/tx_ctrl_pkg.sv
package tx_ctrl_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] DRIVER_LATCH_OFFSET = 8'h08;
  localparam logic [7:0] SELFTEST_LATCH_OFFSET = 8'h0C;

  // control register fields
  localparam int CTRL_DRIVER_OFF_BIT = 0;
  localparam int CTRL_SELFTEST_OFF_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // latch widths and cleared values
  localparam int BUS_WIDTH = 8;
  localparam int DRIVER_COUNT = 8;
  localparam int CHANNEL_COUNT = 4;
  localparam logic [7:0] DRIVER_LATCH_RESET = 8'h00;
  localparam logic [7:0] SELFTEST_LATCH_RESET = 8'hFF;

  // outputs settle in fewer than 16 reference cycles after release
  localparam int SETTLE_LIMIT = 16;
  // the count stops one short so the settled flag is registered on the fifteenth edge
  localparam logic [3:0] SETTLE_CYCLES = 4'(SETTLE_LIMIT - 2);

  // three-level pin as seen by the level detectors
  typedef enum logic [1:0] {
    PIN_LOW = 2'b00,
    PIN_MID = 2'b01,
    PIN_HIGH = 2'b10,
    PIN_FLOAT = 2'b11
  } three_level_t;

  // pll bit-rate range
  typedef enum logic [1:0] {
    RANGE_195_400 = 2'b00,
    RANGE_400_800 = 2'b01,
    RANGE_800_1500 = 2'b10
  } rate_range_t;

  // reset sequencer, gray along reset -> settle -> run
  typedef enum logic [1:0] {
    SEQ_RESET = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_RUN = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [23:0] unused;
    logic capture_on_reference;
    logic half_rate;
    logic config_invalid;
    logic outputs_settled;
    logic [1:0] seq_state;
    logic [1:0] rate_range;
  } status_t;

endpackage

//--- rtl/tx_enable_latch_reset_ctrl.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module tx_enable_latch_reset_ctrl #(
  parameter logic [23:0] DRIVER_MAP = {3'd7, 3'd6, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0},
  parameter logic [11:0] CHANNEL_MAP = {3'd3, 3'd2, 3'd1, 3'd0}
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic device_reset_n,
  input wire logic [1:0] rate_range_select,
  input wire logic half_rate_clock_mode,
  input wire logic transmit_clock_select,
  input wire logic output_latch_enable,
  input wire logic selftest_latch_enable,
  input wire logic [7:0] shared_enable_bus,
  output logic [7:0] serial_output_driver,
  output logic [3:0] channel_selftest_active,
  output logic [1:0] pll_rate_range,
  output logic capture_on_reference,
  output logic config_invalid,
  output logic outputs_settled
);

  logic [7:0] driver_latch;
  logic [7:0] selftest_latch;
  logic [1:0] ctrl;
  logic [3:0] settle_count;
  tx_ctrl_pkg::seq_state_t seq_state;
  tx_ctrl_pkg::seq_state_t next_seq_state;

  // bus bit selected by a 3-bit entry of a mapping table
  function automatic logic pick_bit(input logic [7:0] bus, input logic [2:0] index);
    pick_bit = bus[index];
  endfunction

  // ---------------- three-level select and static pins ----------------
  wire tx_ctrl_pkg::three_level_t select_level = tx_ctrl_pkg::three_level_t'(rate_range_select);
  wire tx_ctrl_pkg::rate_range_t next_range =
    (select_level == tx_ctrl_pkg::PIN_LOW) ? tx_ctrl_pkg::RANGE_195_400 :
    (select_level == tx_ctrl_pkg::PIN_HIGH) ? tx_ctrl_pkg::RANGE_800_1500 :
    tx_ctrl_pkg::RANGE_400_800;
  wire next_invalid = (next_range == tx_ctrl_pkg::RANGE_195_400) && half_rate_clock_mode;
  wire next_capture_ref = !transmit_clock_select;

  // ---------------- reset sequencer ----------------
  wire settle_done = (settle_count == tx_ctrl_pkg::SETTLE_CYCLES);

  always_comb
  begin
    next_seq_state = seq_state;
    unique case (seq_state)
      tx_ctrl_pkg::SEQ_RESET:
        next_seq_state = tx_ctrl_pkg::SEQ_SETTLE;
      tx_ctrl_pkg::SEQ_SETTLE:
        if (settle_done)
          next_seq_state = tx_ctrl_pkg::SEQ_RUN;
      tx_ctrl_pkg::SEQ_RUN:
        next_seq_state = tx_ctrl_pkg::SEQ_RUN;
      default:
        next_seq_state = tx_ctrl_pkg::SEQ_RESET;
    endcase
    if (!device_reset_n)
      next_seq_state = tx_ctrl_pkg::SEQ_RESET;
  end

  wire [3:0] next_settle_count =
    (!device_reset_n || seq_state != tx_ctrl_pkg::SEQ_SETTLE) ? 4'h0 :
    settle_done ? settle_count : settle_count + 4'h1;

  wire next_settled = (next_seq_state == tx_ctrl_pkg::SEQ_RUN);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_state <= tx_ctrl_pkg::SEQ_RESET;
    end
    else
    begin
      seq_state <= next_seq_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle_count <= 4'h0;
    end
    else
    begin
      settle_count <= next_settle_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      outputs_settled <= 1'b0;
    end
    else
    begin
      outputs_settled <= next_settled;
    end
  end

  // ---------------- enable latches ----------------
  // the pins are asynchronous latch gates; here they are sampled each reference
  // edge, so a pulse that falls between two edges is not seen
  // reset clears drivers
  wire [7:0] next_driver_latch =
    !device_reset_n ? tx_ctrl_pkg::DRIVER_LATCH_RESET :
    output_latch_enable ? shared_enable_bus : driver_latch;

  wire [7:0] next_selftest_latch =
    selftest_latch_enable ? shared_enable_bus :
    !device_reset_n ? tx_ctrl_pkg::SELFTEST_LATCH_RESET : selftest_latch;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      driver_latch <= tx_ctrl_pkg::DRIVER_LATCH_RESET;
    end
    else
    begin
      driver_latch <= next_driver_latch;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      selftest_latch <= tx_ctrl_pkg::SELFTEST_LATCH_RESET;
    end
    else
    begin
      selftest_latch <= next_selftest_latch;
    end
  end

  // ---------------- mapping to drivers and channels ----------------
  logic [7:0] next_drivers;
  logic [3:0] next_selftest;

  genvar g;
  generate
    for (g = 0; g < tx_ctrl_pkg::DRIVER_COUNT; g++)
    begin : gen_driver
      assign next_drivers[g] = pick_bit(next_driver_latch, DRIVER_MAP[3*g +: 3]) &&
                               !ctrl[tx_ctrl_pkg::CTRL_DRIVER_OFF_BIT];
    end
    for (g = 0; g < tx_ctrl_pkg::CHANNEL_COUNT; g++)
    begin : gen_channel
      assign next_selftest[g] = !pick_bit(next_selftest_latch, CHANNEL_MAP[3*g +: 3]) &&
                                !ctrl[tx_ctrl_pkg::CTRL_SELFTEST_OFF_BIT];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_output_driver <= tx_ctrl_pkg::DRIVER_LATCH_RESET;
    end
    else
    begin
      serial_output_driver <= next_drivers;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_selftest_active <= 4'h0;
    end
    else
    begin
      channel_selftest_active <= next_selftest;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_rate_range <= tx_ctrl_pkg::RANGE_400_800;
    end
    else
    begin
      pll_rate_range <= next_range;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capture_on_reference <= 1'b1;
    end
    else
    begin
      capture_on_reference <= next_capture_ref;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      config_invalid <= 1'b0;
    end
    else
    begin
      config_invalid <= next_invalid;
    end
  end

  // ---------------- apb slave ----------------
  // no wait state: pready rises in the first access cycle, registered from the setup
  // phase, which keeps prdata a flop output without adding a cycle per transfer
  wire setup_phase = psel && !penable && !pready;
  wire write_fire = psel && penable && pready && pwrite;
  wire hit_ctrl = (paddr == tx_ctrl_pkg::CTRL_OFFSET);
  wire hit_status = (paddr == tx_ctrl_pkg::STATUS_OFFSET);
  wire hit_driver = (paddr == tx_ctrl_pkg::DRIVER_LATCH_OFFSET);
  wire hit_selftest = (paddr == tx_ctrl_pkg::SELFTEST_LATCH_OFFSET);
  wire addr_mapped = hit_ctrl || hit_status || hit_driver || hit_selftest;

  tx_ctrl_pkg::status_t status_word;
  assign status_word.unused = 24'h00_0000;
  assign status_word.capture_on_reference = capture_on_reference;
  assign status_word.half_rate = half_rate_clock_mode;
  assign status_word.config_invalid = config_invalid;
  assign status_word.outputs_settled = outputs_settled;
  assign status_word.seq_state = seq_state;
  assign status_word.rate_range = pll_rate_range;

  wire [31:0] read_word =
    hit_ctrl ? {30'h0, ctrl} :
    hit_status ? status_word :
    hit_driver ? {24'h0, driver_latch} :
    hit_selftest ? {24'h0, selftest_latch} : 32'h0000_0000;

  wire [1:0] next_ctrl = (write_fire && hit_ctrl && pstrb[0]) ? pwdata[1:0] : ctrl;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= setup_phase && !addr_mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else
    begin
      prdata <= (setup_phase && !pwrite) ? read_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= tx_ctrl_pkg::CTRL_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

endmodule

`default_nettype wire
